// ---- hw/fls_force_limit.sv ----
// force limit selector: picks forward and reverse force limits in percent
// assumes analogue inputs arrive as signed codes synchronous to clk_i,
// and the discrete inputs are already debounced by the controller
//
// Notes on behaviour
// RULE_01 - select 0: forward from analogue in2 positive, reverse from in3 negative
// RULE_02 - select 1: first limit applies forward and reverse
// RULE_03 - select 2: first limit forward, second limit reverse
// RULE_04 - select 3, switch input off: first limit both directions
// RULE_05 - select 3, switch input on: second limit both directions
// RULE_06 - select 4: forward from in2, reverse from in3, both positive span
// RULE_07 - select 5: forward analogue input limits both directions
// RULE_08 - select 6, switch off: first limit forward, second reverse
// RULE_09 - select 6, switch on: external forward and reverse limits
// RULE_10 - force control mode always uses the first limit
// RULE_11 - with feed-forward, limit applies only in speed mode, select 1..3
// RULE_12 - ramping between limits happens only with select 3
// RULE_13 - first to second transition uses the one-to-two rate
// RULE_14 - second to first transition uses the two-to-one rate
// RULE_15 - ramp direction follows comparison of current and target limit
// RULE_16 - software write of first or second limit applies at once
// RULE_17 - limits accept 0 to 500 percent and reset to 500
// RULE_18 - output is the lower of chosen limit and current cap
// RULE_19 - analogue limit multiplied by programmable scale
// RULE_20 - analogue inputs get offset correction and first-order lag filter
// RULE_21 - ramp steps once per control cycle, stops exactly on target
// RULE_22 - controller holds switch input stable at least one control cycle
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`include "fls_params.svh"

module fls_force_limit #(
  parameter int CTRL_DIV = `FLS_CTRL_CYCLES
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire fls_pkg::fls_wb_req_t wb_req_i,
  output logic                      wb_ack_o,
  output logic [31:0]               wb_dat_o,
  input  wire logic signed [12:0]   fwd_analog_limit_i,
  input  wire logic signed [12:0]   rev_analog_limit_i,
  input  wire logic                 limit_switch_select_i,
  input  wire logic                 force_mode_i,
  input  wire logic                 speed_mode_i,
  input  wire logic                 feedforward_sel_i,
  input  wire logic [9:0]           current_cap_i,
  output logic [9:0]                fwd_limit_o,
  output logic [9:0]                rev_limit_o,
  output logic                      limit_apply_o,
  output logic                      ramp_active_o
);

  // the tick counter is 16 bits wide in the state struct
  if (CTRL_DIV < 1 || CTRL_DIV > 65535) begin : g_bad_div
    $error("CTRL_DIV out of range");
  end
  localparam logic [15:0] DIV_LAST = 16'(CTRL_DIV - 1);

  fls_pkg::fls_state_t q;
  fls_pkg::fls_state_t d;

  logic       tick;
  logic       acc;
  logic       wr;
  logic [9:0] tgt;
  logic [9:0] rate;

  // lower of two limits
  function automatic logic [9:0] lo10(input logic [9:0] a,
                                      input logic [9:0] b);
    lo10 = (a < b) ? a : b;
  endfunction

  // clamp a raw setting into the legal percent range
  function automatic logic [9:0] clamp_lim(input logic [9:0] v);
    clamp_lim = lo10(v, `FLS_LIM_MAX);
  endfunction

  // positive part of a signed code, as a 12-bit magnitude
  function automatic logic [11:0] pos_mag(input logic signed [13:0] v);
    if (v <= 14'sh0000)
      pos_mag = 12'h000;
    else if (v > 14'sh0FFF)
      pos_mag = 12'hFFF;
    else
      pos_mag = v[11:0];
  endfunction

  // scaled analogue magnitude as a percent limit
  function automatic logic [9:0] ana_lim(input logic [11:0] mag,
                                         input logic [9:0]  scl);
    logic [21:0] prod;
    logic [9:0]  pct;
    prod = 22'(mag) * 22'(scl);
    pct  = prod[21:`FLS_ANA_SHIFT];
    ana_lim = clamp_lim(pct);
  endfunction

  // saturate a 14-bit signed value to the 13-bit code range
  function automatic logic signed [12:0] sat13(input logic signed [13:0] v);
    if (v > 14'sh0FFF)
      sat13 = 13'sh0FFF;
    else if (v < -14'sh1000)
      sat13 = -13'sh1000;
    else
      sat13 = v[12:0];
  endfunction

  // one step of a first-order lag: y += (x - off - y) >> tc
  function automatic logic signed [12:0] lag(
      input logic signed [12:0] x,
      input logic signed [12:0] off,
      input logic signed [12:0] y,
      input logic [3:0]         tc);
    logic signed [13:0] xc;
    logic signed [14:0] diff;
    logic signed [14:0] step;
    xc   = 14'(sat13(14'(x) - 14'(off)));
    diff = 15'(xc) - 15'(y);
    step = diff >>> tc;
    lag  = sat13(14'(15'(y) + step));
  endfunction

  // byte-lane merge of a write into a narrow register
  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  bsel);
    wmerge[7:0]  = bsel[0] ? dat[7:0]  : old[7:0];
    wmerge[15:8] = bsel[1] ? dat[15:8] : old[15:8];
  endfunction

  // register word as software reads it; writes merge into the same view
  function automatic logic [31:0] reg_word(input fls_pkg::fls_state_t s,
                                           input logic              busy,
                                           input logic [7:0]        adr);
    case (adr)
      `FLS_ADR_SELECT:  reg_word = {29'h00000000, s.sel};
      `FLS_ADR_FIRST:   reg_word = {22'h000000, s.lim1};
      `FLS_ADR_SECOND:  reg_word = {22'h000000, s.lim2};
      `FLS_ADR_RATE12:  reg_word = {22'h000000, s.rate12};
      `FLS_ADR_RATE21:  reg_word = {22'h000000, s.rate21};
      `FLS_ADR_FWD_EXT: reg_word = {22'h000000, s.fext};
      `FLS_ADR_REV_EXT: reg_word = {22'h000000, s.rext};
      `FLS_ADR_SCALE:   reg_word = {22'h000000, s.scale};
      `FLS_ADR_IN2_OFS: reg_word = {19'h00000, s.off2};
      `FLS_ADR_IN2_TC:  reg_word = {28'h0000000, s.tc2};
      `FLS_ADR_IN3_OFS: reg_word = {19'h00000, s.off3};
      `FLS_ADR_IN3_TC:  reg_word = {28'h0000000, s.tc3};
      `FLS_ADR_STATUS:  reg_word = {10'h000, busy, s.apply, s.rev, s.fwd};
      default:          reg_word = 32'h00000000;
    endcase
  endfunction

  // bus strobes: one ack per request, dropped the cycle after
  assign acc  = wb_req_i.cyc & wb_req_i.stb & ~q.ack;
  assign wr   = acc & wb_req_i.we;
  assign tick = (q.tick_cnt == DIV_LAST);

  // ramp target and rate follow the switch input
  assign tgt  = limit_switch_select_i ? q.lim2 : q.lim1; // RULE_04 RULE_05
  assign rate = limit_switch_select_i ? q.rate12 : q.rate21; // RULE_13 RULE_14

  // next-state logic for the whole block
  always_comb begin
    logic [9:0]  fsel;
    logic [9:0]  rsel;
    logic [9:0]  a2p;
    logic [9:0]  a3p;
    logic [9:0]  a3n;
    logic [9:0]  gap;
    logic [15:0] nv;
    logic [31:0] cur;
    fsel = 10'h000;
    rsel = 10'h000;
    gap  = 10'h000;
    nv   = 16'h0000;
    cur  = 32'h00000000;
    // scaled analogue limits from the filtered codes
    a2p  = ana_lim(pos_mag(14'(q.filt2)), q.scale);  // RULE_19
    a3p  = ana_lim(pos_mag(14'(q.filt3)), q.scale);  // RULE_19
    a3n  = ana_lim(pos_mag(-14'(q.filt3)), q.scale); // RULE_19
    d = q;
    d.ack = acc;
    d.tick_cnt = tick ? 16'h0000 : q.tick_cnt + 16'h0001;

    // analogue conditioning once per control cycle
    if (tick) begin
      d.filt2 = lag(fwd_analog_limit_i, q.off2, q.filt2, q.tc2); // RULE_20
      d.filt3 = lag(rev_analog_limit_i, q.off3, q.filt3, q.tc3); // RULE_20
    end

    // ramp: follows at once unless ramped select, no pending snap and a nonzero rate
    if (q.sel != `FLS_SEL_RAMPED || q.snap || rate == 10'h000) begin
      d.ramp = tgt; // RULE_12 RULE_16
      d.snap = 1'b0;
    end else if (tick) begin
      if (q.ramp < tgt) begin
        gap = tgt - q.ramp;
        d.ramp = q.ramp + lo10(rate, gap); // RULE_15 RULE_21
      end else begin
        gap = q.ramp - tgt;
        d.ramp = q.ramp - lo10(rate, gap); // RULE_15 RULE_21
      end
    end

    // source selection
    case (q.sel)
      3'h0: begin
        fsel = a2p; // RULE_01
        rsel = a3n; // RULE_01
      end
      3'h1: begin
        fsel = q.lim1; // RULE_02
        rsel = q.lim1; // RULE_02
      end
      3'h2: begin
        fsel = q.lim1; // RULE_03
        rsel = q.lim2; // RULE_03
      end
      3'h3: begin
        fsel = q.ramp; // RULE_04 RULE_05
        rsel = q.ramp;
      end
      3'h4: begin
        fsel = a2p; // RULE_06
        rsel = a3p; // RULE_06
      end
      3'h5: begin
        fsel = a2p; // RULE_07
        rsel = a2p; // RULE_07
      end
      3'h6: begin
        fsel = limit_switch_select_i ? q.fext : q.lim1; // RULE_08 RULE_09
        rsel = limit_switch_select_i ? q.rext : q.lim2; // RULE_08 RULE_09
      end
      default: begin
        // code 7 cannot be written; kept safe anyway
        fsel = q.lim1;
        rsel = q.lim1;
      end
    endcase
    if (force_mode_i) begin
      fsel = q.lim1; // RULE_10
      rsel = q.lim1; // RULE_10
    end
    d.fwd = lo10(fsel, current_cap_i); // RULE_18
    d.rev = lo10(rsel, current_cap_i); // RULE_18
    d.apply = ~feedforward_sel_i |
              (speed_mode_i & ~force_mode_i &
               q.sel >= 3'h1 & q.sel <= 3'h3); // RULE_11

    // register writes merge byte lanes into the current word; a limit
    // write also forces an immediate apply past any ramp in progress
    if (wr) begin
      cur = reg_word(q, 1'b0, wb_req_i.adr);
      nv  = wmerge(cur[15:0], wb_req_i.dat, wb_req_i.sel);
      case (wb_req_i.adr)
        `FLS_ADR_SELECT: begin
          if (nv[2:0] <= `FLS_SEL_LAST)
            d.sel = nv[2:0];
        end
        `FLS_ADR_FIRST: begin
          d.lim1 = clamp_lim(nv[9:0]); // RULE_17
          d.snap = 1'b1;               // RULE_16
        end
        `FLS_ADR_SECOND: begin
          d.lim2 = clamp_lim(nv[9:0]); // RULE_17
          d.snap = 1'b1;               // RULE_16
        end
        `FLS_ADR_RATE12:  d.rate12 = nv[9:0];
        `FLS_ADR_RATE21:  d.rate21 = nv[9:0];
        `FLS_ADR_FWD_EXT: d.fext   = clamp_lim(nv[9:0]); // RULE_17
        `FLS_ADR_REV_EXT: d.rext   = clamp_lim(nv[9:0]); // RULE_17
        `FLS_ADR_SCALE:   d.scale  = nv[9:0];
        `FLS_ADR_IN2_OFS: d.off2   = nv[12:0];
        `FLS_ADR_IN2_TC:  d.tc2    = nv[3:0];
        `FLS_ADR_IN3_OFS: d.off3   = nv[12:0];
        `FLS_ADR_IN3_TC:  d.tc3    = nv[3:0];
        default: begin
          // status and unmapped words ignore writes
        end
      endcase
    end
    // read data, registered alongside the ack
    if (acc)
      d.rdata = reg_word(q, q.ramp != tgt, wb_req_i.adr);
  end

  // state register; reset leaves every limit at its widest setting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q          <= '0;
      q.sel      <= `FLS_SEL_RESET;
      q.lim1     <= `FLS_LIM_RESET; // RULE_17
      q.lim2     <= `FLS_LIM_RESET; // RULE_17
      q.fext     <= `FLS_LIM_RESET; // RULE_17
      q.rext     <= `FLS_LIM_RESET; // RULE_17
      q.scale    <= `FLS_SCALE_RESET;
      q.ramp     <= `FLS_LIM_RESET;
      q.fwd      <= `FLS_LIM_RESET;
      q.rev      <= `FLS_LIM_RESET;
      q.apply    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state flops, except ramp_active_o, which compares q.ramp with tgt
  assign wb_ack_o      = q.ack;
  assign wb_dat_o      = q.rdata;
  assign fwd_limit_o   = q.fwd;
  assign rev_limit_o   = q.rev;
  assign limit_apply_o = q.apply;
  assign ramp_active_o = (q.sel == `FLS_SEL_RAMPED) && (q.ramp != tgt);

  // checks on the selection path
  property p_sel_one;
    @(posedge clk_i) disable iff (rst_i)
    (q.sel == 3'h1 && !force_mode_i) |=>
      fwd_limit_o == lo10($past(q.lim1), $past(current_cap_i)) &&
      rev_limit_o == fwd_limit_o;
  endproperty
  a_sel_one: assert property (p_sel_one) // RULE_02
    else $error("select 1 did not give first limit both ways");

  property p_sel_two;
    @(posedge clk_i) disable iff (rst_i)
    (q.sel == 3'h2 && !force_mode_i) |=>
      rev_limit_o == lo10($past(q.lim2), $past(current_cap_i));
  endproperty
  a_sel_two: assert property (p_sel_two) // RULE_03
    else $error("select 2 reverse limit is not the second limit");

  property p_sel_six_ext;
    @(posedge clk_i) disable iff (rst_i)
    (q.sel == 3'h6 && limit_switch_select_i && !force_mode_i) |=>
      fwd_limit_o == lo10($past(q.fext), $past(current_cap_i));
  endproperty
  a_sel_six_ext: assert property (p_sel_six_ext) // RULE_09
    else $error("select 6 with switch on ignored external limit");

  property p_force_mode;
    @(posedge clk_i) disable iff (rst_i)
    force_mode_i |=>
      fwd_limit_o == lo10($past(q.lim1), $past(current_cap_i)) &&
      rev_limit_o == fwd_limit_o;
  endproperty
  a_force_mode: assert property (p_force_mode) // RULE_10
    else $error("force mode did not use first limit");

  property p_ff_gate;
    @(posedge clk_i) disable iff (rst_i)
    (feedforward_sel_i && !speed_mode_i) |=> !limit_apply_o;
  endproperty
  a_ff_gate: assert property (p_ff_gate) // RULE_11
    else $error("feed-forward limit applied outside speed mode");

  // checks on the ramp
  property p_no_overshoot;
    @(posedge clk_i) disable iff (rst_i)
    (q.sel == `FLS_SEL_RAMPED && q.ramp <= tgt && $stable(tgt)) |=>
      q.ramp <= $past(tgt);
  endproperty
  a_no_overshoot: assert property (p_no_overshoot) // RULE_21
    else $error("ramp passed its target");

  property p_step_size;
    @(posedge clk_i) disable iff (rst_i)
    (q.sel == `FLS_SEL_RAMPED && !q.snap && tick && rate != 10'h000 &&
     q.ramp < tgt) |=>
      (q.ramp - $past(q.ramp)) <= $past(rate) && q.ramp > $past(q.ramp);
  endproperty
  a_step_size: assert property (p_step_size) // RULE_13
    else $error("ramp step not bounded by the active rate");

  property p_hold_between_ticks;
    @(posedge clk_i) disable iff (rst_i)
    (q.sel == `FLS_SEL_RAMPED && !q.snap && rate != 10'h000 && !tick &&
     $past(q.sel) == `FLS_SEL_RAMPED) |=> $stable(q.ramp) || q.snap;
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks) // RULE_21
    else $error("ramp moved outside a control cycle tick");

  // a limit write snaps the ramp two cycles later
  sequence s_lim_write;
    wr && (wb_req_i.adr == `FLS_ADR_FIRST ||
           wb_req_i.adr == `FLS_ADR_SECOND);
  endsequence

  sequence s_snap_done;
    q.snap ##1 (q.ramp == $past(tgt));
  endsequence

  property p_snap;
    @(posedge clk_i) disable iff (rst_i)
    s_lim_write |=> s_snap_done;
  endproperty
  a_snap: assert property (p_snap) // RULE_16
    else $error("limit write did not apply at once");

  property p_range;
    @(posedge clk_i) disable iff (rst_i)
    q.lim1 <= `FLS_LIM_MAX && q.lim2 <= `FLS_LIM_MAX &&
    (fwd_limit_o <= current_cap_i && rev_limit_o <= current_cap_i ||
     $past(current_cap_i) != current_cap_i || $past(rst_i));
  endproperty
  a_range: assert property (p_range) // RULE_17
    else $error("limit outside legal range or above cap");

  // bus handshake
  sequence s_bus_req;
    wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  endsequence

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
    s_bus_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("bus ack not a single cycle after request");

endmodule // fls_force_limit

// ---- hw/fls_params.svh ----
// constants for the force limit selector: offsets, fields, resets, timing
// assumes a 200 MHz system clock and a Wishbone byte-addressed register map
`ifndef FLS_PARAMS_SVH
`define FLS_PARAMS_SVH

// register byte offsets, one aligned 32-bit word each
`define FLS_ADR_SELECT     8'h00
`define FLS_ADR_FIRST      8'h04
`define FLS_ADR_SECOND     8'h08
`define FLS_ADR_RATE12     8'h0C
`define FLS_ADR_RATE21     8'h10
`define FLS_ADR_FWD_EXT    8'h14
`define FLS_ADR_REV_EXT    8'h18
`define FLS_ADR_SCALE      8'h1C
`define FLS_ADR_IN2_OFS    8'h20
`define FLS_ADR_IN2_TC     8'h24
`define FLS_ADR_IN3_OFS    8'h28
`define FLS_ADR_IN3_TC     8'h2C
`define FLS_ADR_STATUS     8'h30

// status word field positions
`define FLS_ST_FWD_LSB     0
`define FLS_ST_REV_LSB     10
`define FLS_ST_APPLY_BIT   20
`define FLS_ST_RAMP_BIT    21

// limits in percent of rated force
`define FLS_LIM_MAX        10'h1F4
`define FLS_LIM_RESET      10'h1F4
`define FLS_SCALE_RESET    10'h064
`define FLS_SEL_RESET      3'h1
`define FLS_SEL_LAST       3'h6
`define FLS_SEL_RAMPED     3'h3

// analogue code: 4096 counts of magnitude span 10 V
`define FLS_ANA_SHIFT      12

// control cycle timing
`define FLS_CLK_PERIOD_NS  5
`define FLS_CTRL_CYCLE_NS  62500
`define FLS_CTRL_CYCLES    (`FLS_CTRL_CYCLE_NS / `FLS_CLK_PERIOD_NS)

`endif

// ---- hw/fls_pkg.sv ----
// types for the force limit selector
// assumes the constants header is included by the files that use it
package fls_pkg;

  // classic Wishbone request from the bus master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } fls_wb_req_t;

  // the whole state of the selector
  typedef struct packed {
    logic [2:0]         sel;
    logic [9:0]         lim1;
    logic [9:0]         lim2;
    logic [9:0]         rate12;
    logic [9:0]         rate21;
    logic [9:0]         fext;
    logic [9:0]         rext;
    logic [9:0]         scale;
    logic signed [12:0] off2;
    logic signed [12:0] off3;
    logic [3:0]         tc2;
    logic [3:0]         tc3;
    logic signed [12:0] filt2;
    logic signed [12:0] filt3;
    logic [9:0]         ramp;
    logic               snap;
    logic [15:0]        tick_cnt;
    logic [9:0]         fwd;
    logic [9:0]         rev;
    logic               apply;
    logic               ack;
    logic [31:0]        rdata;
  } fls_state_t;

endpackage

// ---- verif/fls_host.sv ----
// host controller model: analogue limit codes and discrete mode inputs
// assumes the bench calls its tasks between edges of clk_i
`timescale 1ns/10ps

module fls_host #(
  parameter int HOLD = 4
) (
  input  wire logic          clk_i,
  output logic signed [12:0] fwd_code_o,
  output logic signed [12:0] rev_code_o,
  output logic               sw_o,
  output logic               force_o,
  output logic               speed_o,
  output logic               ff_o,
  output logic [9:0]         cap_o
);
  // idle levels: zero volts, switch off, speed mode, full cap
  initial begin
    fwd_code_o = 13'h0000;
    rev_code_o = 13'h0000;
    sw_o       = 1'h0;
    force_o    = 1'h0;
    speed_o    = 1'h1;
    ff_o       = 1'h0;
    cap_o      = 10'h1F4;
  end

  // a full control cycle passes before any input moves, so the
  // selector never samples a switch level that is only half there
  task automatic set_in(input logic sw, input logic fm, input logic sm,
                        input logic ff, input logic [9:0] cap);
    repeat (HOLD) @(posedge clk_i);
    sw_o    <= sw;
    force_o <= fm;
    speed_o <= sm;
    ff_o    <= ff;
    cap_o   <= cap;
  endtask

  // analogue levels change just after an edge
  task automatic set_ana(input logic [12:0] f, input logic [12:0] r);
    @(posedge clk_i);
    fwd_code_o <= f;
    rev_code_o <= r;
  endtask
endmodule // fls_host

// ---- verif/tb.sv ----
// bench for the force limit selector: wishbone tasks plus host model
// assumes fls_params.svh on the include path and fls_pkg compiled first
`timescale 1ns/10ps
`include "fls_params.svh"

module tb;
  localparam int DIV = 4;
  logic                 clk_i;
  logic                 rst_i;
  fls_pkg::fls_wb_req_t req;
  logic                 ack;
  logic [31:0]          dat;
  logic signed [12:0]   fcode;
  logic signed [12:0]   rcode;
  logic                 sw, fm, sm, ff, apply, ramp_on;
  logic [9:0]           cap, fwd, rev;
  int                   mismatches = 0;
  int                   num_checks = 0;
  int                   cyc_cnt = 0;
  logic [7:0]           ra [8] = '{`FLS_ADR_SELECT, `FLS_ADR_FIRST,
    `FLS_ADR_SECOND, `FLS_ADR_FWD_EXT, `FLS_ADR_REV_EXT, `FLS_ADR_SCALE,
    `FLS_ADR_RATE12, `FLS_ADR_IN2_OFS};
  logic [31:0]          rv [8] = '{32'h1, 32'h1F4, 32'h1F4, 32'h1F4,
    32'h1F4, 32'h64, 32'h0, 32'h0};

  fls_force_limit #(.CTRL_DIV(DIV)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(dat),
    .fwd_analog_limit_i(fcode), .rev_analog_limit_i(rcode),
    .limit_switch_select_i(sw), .force_mode_i(fm), .speed_mode_i(sm),
    .feedforward_sel_i(ff), .current_cap_i(cap), .fwd_limit_o(fwd),
    .rev_limit_o(rev), .limit_apply_o(apply), .ramp_active_o(ramp_on));

  fls_host #(.HOLD(DIV)) u_host (.clk_i(clk_i), .fwd_code_o(fcode),
    .rev_code_o(rcode), .sw_o(sw), .force_o(fm), .speed_o(sm),
    .ff_o(ff), .cap_o(cap));

  // 200 MHz clock
  initial clk_i = 1'h0;
  always #2.5 clk_i = ~clk_i;

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 4000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    req <= '{cyc:1'h1, stb:1'h1, we:we, adr:a, sel:4'hF, dat:wd};
    // no answer time assumed; only the hang guard ends this wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'h1);
    rd = dat;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    wb(1'h1, a, d, v);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    wb(1'h0, a, 32'h0, v);
    chk(v, e);
  endtask

  // limits are registered, so give them a few edges to land
  task automatic lim(input logic [9:0] f, input logic [9:0] r);
    repeat (3) @(posedge clk_i);
    chk(32'(fwd), 32'(f));
    chk(32'(rev), 32'(r));
  endtask

  // follow each ramp step: exact size, clipped at target, step count
  task automatic ramp(input int tgt, input int step, input int steps);
    int p, e, n, k;
    p = int'(fwd);
    n = 0;
    for (k = 0; k < 80 && p != tgt; k++) begin
      @(posedge clk_i);
      if (int'(fwd) != p) begin
        n++;
        e = (tgt > p) ? ((p + step > tgt) ? tgt : p + step)
                      : ((p - step < tgt) ? tgt : p - step);
        chk(32'(fwd), 32'(e));
        if (n == 1) chk(32'(ramp_on), 32'h1);
        p = int'(fwd);
      end
    end
    chk(32'(n), 32'(steps));
    lim(10'(tgt), 10'(tgt));
  endtask

  // main sequence
  initial begin
    rst_i = 1'h1;
    req   = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    lim(10'h1F4, 10'h1F4);
    wr(`FLS_ADR_FIRST, 32'h258);
    rd(`FLS_ADR_FIRST, 32'h1F4);
    wr(`FLS_ADR_FIRST, 32'h64);
    wr(`FLS_ADR_SECOND, 32'hC8);
    wr(`FLS_ADR_FWD_EXT, 32'h12C);
    wr(`FLS_ADR_REV_EXT, 32'h190);
    wr(`FLS_ADR_RATE12, 32'h1E);
    wr(`FLS_ADR_RATE21, 32'h32);
    lim(10'h64, 10'h64);
    wr(`FLS_ADR_SELECT, 32'h2);
    lim(10'h64, 10'hC8);
    wr(`FLS_ADR_SELECT, 32'h7);
    rd(`FLS_ADR_SELECT, 32'h2);
    wr(`FLS_ADR_STATUS, 32'h0);
    rd(`FLS_ADR_STATUS, 32'h00132064);
    wr(8'h34, 32'h5);
    rd(8'h34, 32'h0);
    wr(`FLS_ADR_SELECT, 32'h6);
    lim(10'h64, 10'hC8);
    u_host.set_in(1'h1, 1'h0, 1'h1, 1'h0, 10'h1F4);
    lim(10'h12C, 10'h190);
    u_host.set_in(1'h1, 1'h0, 1'h1, 1'h0, 10'h96);
    lim(10'h96, 10'h96);
    u_host.set_in(1'h1, 1'h1, 1'h1, 1'h0, 10'h1F4);
    lim(10'h64, 10'h64);
    u_host.set_in(1'h0, 1'h0, 1'h1, 1'h0, 10'h1F4);
    wr(`FLS_ADR_SELECT, 32'h3);
    lim(10'h64, 10'h64);
    u_host.set_in(1'h1, 1'h0, 1'h1, 1'h0, 10'h1F4);
    ramp(200, 30, 4);
    u_host.set_in(1'h0, 1'h0, 1'h1, 1'h0, 10'h1F4);
    ramp(100, 50, 2);
    chk(32'(ramp_on), 32'h0);
    u_host.set_in(1'h1, 1'h0, 1'h1, 1'h0, 10'h1F4);
    ramp(200, 30, 4);
    wr(`FLS_ADR_SECOND, 32'h190);
    lim(10'h190, 10'h190);
    wr(`FLS_ADR_SELECT, 32'h2);
    u_host.set_in(1'h0, 1'h0, 1'h1, 1'h1, 10'h1F4);
    lim(10'h64, 10'h190);
    chk(32'(apply), 32'h1);
    wr(`FLS_ADR_SELECT, 32'h4);
    repeat (3) @(posedge clk_i);
    chk(32'(apply), 32'h0);
    u_host.set_in(1'h0, 1'h0, 1'h0, 1'h1, 10'h1F4);
    wr(`FLS_ADR_SELECT, 32'h2);
    repeat (3) @(posedge clk_i);
    chk(32'(apply), 32'h0);
    u_host.set_in(1'h0, 1'h0, 1'h1, 1'h0, 10'h1F4);
    u_host.set_ana(13'h0800, 13'h1C00);
    repeat (12) @(posedge clk_i);
    wr(`FLS_ADR_SELECT, 32'h0);
    lim(10'h32, 10'h19);
    wr(`FLS_ADR_SELECT, 32'h4);
    lim(10'h32, 10'h0);
    wr(`FLS_ADR_SELECT, 32'h5);
    lim(10'h32, 10'h32);
    wr(`FLS_ADR_IN2_OFS, 32'h400);
    repeat (12) @(posedge clk_i);
    lim(10'h19, 10'h19);
    wr(`FLS_ADR_SCALE, 32'hC8);
    repeat (12) @(posedge clk_i);
    lim(10'h32, 10'h32);
    // longest time constant: a rising step is held back by the filter
    wr(`FLS_ADR_IN2_TC, 32'hF);
    u_host.set_ana(13'h0C00, 13'h1C00);
    repeat (12) @(posedge clk_i);
    lim(10'h32, 10'h32);
    wr(`FLS_ADR_IN2_TC, 32'h0);
    repeat (12) @(posedge clk_i);
    lim(10'h64, 10'h64);
    results();
  end
endmodule // tb
